/* File: bench/estu_core_test.sv */
// Self-checking bench for the time-interval unit
`timescale 1ns/1ps
module estu_core_test;
   logic             aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sync_in, sync_idle;
   logic             awready, wready, bvalid, arready, rvalid, result_clk;
   logic [7:0]       awaddr, araddr;
   logic [31:0]      wdata, rdata;
   logic [3:0]       wstrb, event_in, result_data, result_strobe, rx_err, ev_idle;
   logic [1:0]       bresp, rresp;
   logic [3:0][39:0] rx_word;
   logic [3:0][5:0]  rx_len;
   logic [3:0][7:0]  rx_count;
   logic [39:0]      got;
   int               failures, checks, cycles;
   localparam logic [1:0] OK = estu_pkg::RESP_OKAY;
   ////////////////////////////////////////////////////////////
   // Unit under test and far-side receiver
   estu_core #(.DEPTH(4)) i_estu_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .event_in(event_in),
      .sync_in(sync_in), .result_clk(result_clk), .result_data(result_data), .result_strobe(result_strobe));
   estu_rx_model i_estu_rx_model (.result_clk(result_clk), .aresetn(aresetn), .result_data(result_data),
      .result_strobe(result_strobe), .rx_word(rx_word), .rx_len(rx_len), .rx_count(rx_count), .rx_err(rx_err));
   // Clock and hang guard
   initial aclk = 1'b0;
   always #2.5 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures++;
         $display("[ERR] %0t run timed out", $time);
         results();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [39:0] g, input logic [39:0] e, input string m);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   // Bus write: both halves offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awready === 1'b1 && !aw_ok) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1 && !w_ok) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      // bready stays high, so back-to-back writes never lower and raise it in one step
      do @(posedge aclk); while (bvalid !== 1'b1);
      chk({38'h0, bresp}, {38'h0, r}, "write response");
   endtask
   // Bus read with data and response compare
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      chk({8'h0, rdata}, {8'h0, e}, "read data");
      chk({38'h0, rresp}, {38'h0, r}, "read response");
   endtask
   // Wait for the receiver to finish the next frame of a channel
   task automatic wait_frame(input int c, output logic [39:0] w);
      logic [7:0] n0;
      n0 = rx_count[c];
      while (rx_count[c] === n0) @(posedge aclk);
      w = rx_word[c];
   endtask
   // One sync and one event, n cycles apart, aligned just after a launch
   task automatic meas(input int c, input int n, input logic ev_first, input logic [5:0] len);
      logic [39:0] e, m;
      e = ev_first ? -40'(6 * n) : 40'(6 * n);
      m = (len == estu_pkg::MAX_WORD_LEN) ? '1 : (40'h1 << len) - 40'h1;
      @(negedge result_clk);
      @(posedge aclk);
      if (ev_first) event_in[c] <= ~ev_idle[c];
      else sync_in <= ~sync_idle;
      repeat (n) @(posedge aclk);
      if (ev_first) sync_in <= ~sync_idle;
      else event_in[c] <= ~ev_idle[c];
      repeat (4) @(posedge aclk);
      sync_in <= sync_idle;
      event_in[c] <= ev_idle[c];
      wait_frame(c, got);
      chk(got, e & m, "result word");
      chk({34'h0, rx_len[c]}, {34'h0, len}, "frame length");
      chk({39'h0, rx_err[c]}, 40'h0, "frame tag or gap");
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      aresetn <= 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, sync_in} <= '0;
      {awaddr, araddr, wdata} <= '0;
      wstrb <= 4'hf;
      event_in <= 4'h0;
      sync_idle = 1'b0;
      ev_idle = 4'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(estu_pkg::ADDR_RES_CFG, {16'h0, estu_pkg::RST_HALF_DIV, 2'h0, estu_pkg::RST_WORD_LEN}, OK);
      axi_rd(estu_pkg::ADDR_SYNC_POL, 32'h0, OK);
      axi_rd(estu_pkg::ADDR_STATUS, 32'h0, OK);
      axi_rd(8'h90, 32'h0, estu_pkg::RESP_DECERR);
      axi_wr(8'h90, 32'hffff_ffff, estu_pkg::RESP_DECERR);
      meas(0, 7, 1'b0, estu_pkg::MAX_WORD_LEN);
      meas(0, 3, 1'b1, estu_pkg::MAX_WORD_LEN);
      axi_wr(estu_pkg::ADDR_RES_CFG, 32'h0000_0810, OK);
      // Every sync and event polarity pair, one per channel
      for (int k = 0; k < 4; k++) begin
         axi_wr(estu_pkg::ADDR_SYNC_POL, {31'h0, k[1]}, OK);
         axi_wr(estu_pkg::ADDR_EV_POL0 + 8'(k) * estu_pkg::ADDR_EV_STRIDE, {31'h0, k[0]}, OK);
         sync_idle = k[1];
         ev_idle[k] = k[0];
         sync_in <= k[1];
         event_in[k] <= k[0];
         repeat (4) @(posedge aclk);
         meas(k, 5 + k, 1'b0, 6'h10);
      end
      axi_rd(8'h20, 32'h1, OK);
      axi_rd(8'h40, 32'h0, OK);
      // Two falling events two cycles apart queue behind one falling sync
      @(negedge result_clk);
      @(posedge aclk);
      sync_in <= 1'b0;
      repeat (4) @(posedge aclk);
      event_in[3] <= 1'b0;
      @(posedge aclk);
      event_in[3] <= 1'b1;
      @(posedge aclk);
      event_in[3] <= 1'b0;
      @(posedge aclk);
      sync_in <= 1'b1;
      event_in[3] <= 1'b1;
      repeat (3) @(posedge aclk);
      axi_rd(estu_pkg::ADDR_STATUS, 32'h0000_0008, OK);
      wait_frame(3, got);
      chk(got, 40'h18, "first queued result");
      wait_frame(3, got);
      chk(got, 40'h24, "second queued result");
      chk({39'h0, rx_err[3]}, 40'h0, "gap between frames");
      // Reset with an event pending sends nothing afterwards
      @(negedge result_clk);
      @(posedge aclk);
      event_in[3] <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b0;
      event_in[3] <= 1'b1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (800) @(posedge aclk);
      chk({32'h0, rx_count[3]}, 40'h0, "frame after reset");
      axi_rd(estu_pkg::ADDR_STATUS, 32'h0, OK);
      results();
   end
endmodule // estu_core_test

/* File: bench/estu_rx_model.sv */
// Receiver model that captures result frames on each channel
`timescale 1ns/1ps
module estu_rx_model (
   // Link from the unit
   input  wire logic             result_clk,
   input  wire logic             aresetn,
   input  wire logic [3:0]       result_data,
   input  wire logic [3:0]       result_strobe,
   // Captured frames
   output logic      [3:0][39:0] rx_word,
   output logic      [3:0][5:0]  rx_len,
   output logic      [3:0][7:0]  rx_count,
   output logic      [3:0]       rx_err
);
   logic [3:0][39:0] shift;
   logic [3:0][5:0]  nbits;
   logic [3:0][1:0]  high;
   logic [3:0]       busy;
   ////////////////////////////////////////////////////////////
   // Sample every channel on the rising result clock
   always @(posedge result_clk or negedge aresetn) begin
      if (!aresetn) begin
         rx_count <= '0;
         rx_err   <= '0;
         busy     <= '0;
         high     <= '0;
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (!result_strobe[c] && !busy[c]) begin
               // A frame opens with the tag, after two idle strobe periods
               busy[c]  <= 1'b1;
               nbits[c] <= '0;
               shift[c] <= '0;
               if (result_data[c] !== estu_pkg::TAG_VALUE || (rx_count[c] != 8'h0 && high[c] < 2'h2))
                  rx_err[c] <= 1'b1;
            end else if (!result_strobe[c]) begin
               shift[c][nbits[c]] <= result_data[c];
               nbits[c]           <= nbits[c] + 6'h1;
            end else begin
               if (busy[c]) begin
                  rx_word[c]  <= shift[c];
                  rx_len[c]   <= nbits[c];
                  rx_count[c] <= rx_count[c] + 8'h1;
               end
               busy[c] <= 1'b0;
               high[c] <= busy[c] ? 2'h1 : high[c] + {1'b0, high[c] != 2'h3};
            end
         end
      end
   end
endmodule // estu_rx_model

/* File: hw/estu_core.sv */
// Four-channel event-to-sync time-interval unit with serial result ports
//
// Behaviour
// - Measure time from qualifying sync edge to event edge, output a digital word.
// - Four independent event channels, all measured against one shared sync input.
// - Timestamps come from a 34-bit free-running counter at 1.2 GHz.
// - Event and sync stamps share one counter and time base.
// - Each valid event edge pushes the current counter value into the FIFO unless the FIFO is full.
// - Result is event stamp from FIFO minus stored sync stamp.
// - After subtraction the difference loads the shifter and goes out serially.
// - One serial result line per channel, all timed by one result clock.
// - Result word length and result transfer speed are programmable.
// - Event edges closer than 5 ns to the last accepted one are ignored.
// - The same 5 ns lockout applies to sync edges.
// - Any rising/falling combination of sync and event edges is supported.
// - Edge-select bit 0 means rising, 1 means falling, for sync and events.
// - Each event channel polarity is set independently of the others.
// - All configuration is written by the host over the register port.
// - Results are 40-bit two's-complement values.
// - Strobe drops, tag then result bits LSB first, sampled on rising clock.
// - After the last bit the strobe is high for two result-clock cycles.
// - A sync edge arriving while an event waits gives the newest sync stamp.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module estu_core #(
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write channels
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Timing inputs
   input  wire logic [3:0]  event_in,
   input  wire logic        sync_in,
   // Serial result outputs
   output logic             result_clk,
   output logic [3:0]       result_data,
   output logic [3:0]       result_strobe
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [2:0] LOCK_RELOAD = 3'(estu_pkg::LOCKOUT_CYC - 1);

   typedef struct packed {
      logic [3:0]                               ev_meta;
      logic [3:0]                               ev_sync;
      logic [3:0]                               ev_prev;
      logic                                     sy_meta;
      logic                                     sy_sync;
      logic                                     sy_prev;
      logic [3:0][2:0]                          lock_ev;
      logic [2:0]                               lock_sy;
      logic [1:0]                               warm;
      logic [estu_pkg::STAMP_W-1:0]             count;
      logic [estu_pkg::STAMP_W-1:0]             sync_stamp;
      logic [3:0]                               ev_pol;
      logic                                     sy_pol;
      logic [5:0]                               word_len;
      logic [7:0]                               half_div;
      logic [7:0]                               div_cnt;
      logic                                     rclk;
      logic [3:0][DEPTH-1:0][estu_pkg::STAMP_W-1:0] fifo;
      logic [3:0][PTR_W:0]                      wr_ptr;
      logic [3:0][PTR_W:0]                      rd_ptr;
      logic [3:0]                               ovf;
      estu_pkg::estu_ch_state_type [3:0]        st;
      logic [3:0][estu_pkg::RESULT_W-1:0]       shreg;
      logic [3:0][5:0]                          bit_cnt;
      logic [3:0][1:0]                          gap_cnt;
      logic [3:0]                               rdat;
      logic [3:0]                               rstb;
      logic                                     aw_held;
      logic [7:0]                               aw_addr;
      logic                                     w_held;
      logic [31:0]                              w_data;
      logic [3:0]                               w_strb;
      logic                                     bvalid;
      logic [1:0]                               bresp;
      logic                                     rvalid;
      logic [31:0]                              rdata;
      logic [1:0]                               rresp;
   } estu_state_type;

   estu_state_type s;
   estu_state_type next_s;
   logic [3:0]     acc_ev;
   logic [3:0]     load_ch;
   logic [3:0]     ch_empty;
   logic [3:0]     ch_full;
   logic [3:0]     ovf_set;
   logic           acc_sy;
   logic           armed;
   logic           tick;
   logic           launch;
   logic [5:0]     eff_len;

   // Edge qualifier: fall=0 picks rising, fall=1 picks falling
   function automatic logic edge_hit(input logic prev, input logic cur, input logic fall);
      edge_hit = fall ? (prev & ~cur) : (~prev & cur);
   endfunction

   // Result: event stamp minus sync stamp, signed over the result width
   function automatic logic [estu_pkg::RESULT_W-1:0] stamp_diff(input logic [estu_pkg::STAMP_W-1:0] ev,
                                                                input logic [estu_pkg::STAMP_W-1:0] sy);
      stamp_diff = {6'h00, ev} - {6'h00, sy};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_s = s;
      acc_ev = 4'h0;
      load_ch = 4'h0;
      ch_empty = 4'h0;
      ch_full = 4'h0;
      ovf_set = 4'h0;
      // Two-flop synchronisers, then a history flop for edge finding
      next_s.ev_meta = event_in;
      next_s.ev_sync = s.ev_meta;
      next_s.ev_prev = s.ev_sync;
      next_s.sy_meta = sync_in;
      next_s.sy_sync = s.sy_meta;
      next_s.sy_prev = s.sy_sync;
      // Shared free-running stamp counter, six fine ticks per clock
      next_s.count = s.count + estu_pkg::STAMP_W'(estu_pkg::TICKS_PER_CLK);
      // Edges count only once the history flops hold real pin levels, so no false edge follows reset
      armed = (s.warm == 2'h3);
      if (s.warm != 2'h3) begin
         next_s.warm = s.warm + 2'h1;
      end
      // Sync capture with retrigger lockout
      acc_sy = edge_hit(s.sy_prev, s.sy_sync, s.sy_pol) && (s.lock_sy == 3'h0) && armed;
      if (acc_sy) begin
         next_s.lock_sy = LOCK_RELOAD;
         next_s.sync_stamp = s.count;
      end else if (s.lock_sy != 3'h0) begin
         next_s.lock_sy = s.lock_sy - 3'h1;
      end
      // Result clock divider; data launches as the clock falls
      tick = (s.div_cnt == 8'h00);
      launch = tick & s.rclk;
      if (tick) begin
         next_s.div_cnt = (s.half_div == 8'h00) ? 8'h00 : s.half_div - 8'h01;
         next_s.rclk = ~s.rclk;
      end else begin
         next_s.div_cnt = s.div_cnt - 8'h01;
      end
      eff_len = ((s.word_len == 6'h00) || (s.word_len > estu_pkg::MAX_WORD_LEN)) ?
                estu_pkg::MAX_WORD_LEN : s.word_len;
      // Per-channel capture, FIFO and serial shifter
      for (int c = 0; c < 4; c++) begin
         ch_empty[c] = (s.wr_ptr[c] == s.rd_ptr[c]);
         ch_full[c] = (s.wr_ptr[c] == {~s.rd_ptr[c][PTR_W], s.rd_ptr[c][PTR_W-1:0]});
         acc_ev[c] = edge_hit(s.ev_prev[c], s.ev_sync[c], s.ev_pol[c]) &&
                     (s.lock_ev[c] == 3'h0) && armed;
         if (acc_ev[c]) begin
            next_s.lock_ev[c] = LOCK_RELOAD;
         end else if (s.lock_ev[c] != 3'h0) begin
            next_s.lock_ev[c] = s.lock_ev[c] - 3'h1;
         end
         if (acc_ev[c] && !ch_full[c]) begin
            next_s.fifo[c][s.wr_ptr[c][PTR_W-1:0]] = s.count;
            next_s.wr_ptr[c] = s.wr_ptr[c] + 1'b1;
         end
         ovf_set[c] = acc_ev[c] & ch_full[c];
         if (launch) begin
            case (s.st[c])
               estu_pkg::CH_IDLE: begin
                  if (!ch_empty[c]) begin
                     load_ch[c] = 1'b1;
                     next_s.shreg[c] = stamp_diff(s.fifo[c][s.rd_ptr[c][PTR_W-1:0]], s.sync_stamp);
                     next_s.rd_ptr[c] = s.rd_ptr[c] + 1'b1;
                     next_s.rstb[c] = 1'b0;
                     next_s.rdat[c] = estu_pkg::TAG_VALUE;
                     next_s.bit_cnt[c] = 6'h00;
                     next_s.st[c] = estu_pkg::CH_SEND;
                  end
               end
               estu_pkg::CH_SEND: begin
                  if (s.bit_cnt[c] == eff_len) begin
                     next_s.rstb[c] = 1'b1;
                     next_s.rdat[c] = 1'b0;
                     next_s.gap_cnt[c] = 2'h0;
                     next_s.st[c] = estu_pkg::CH_GAP;
                  end else begin
                     next_s.rdat[c] = s.shreg[c][0];
                     next_s.shreg[c] = {1'b0, s.shreg[c][estu_pkg::RESULT_W-1:1]};
                     next_s.bit_cnt[c] = s.bit_cnt[c] + 6'h01;
                  end
               end
               estu_pkg::CH_GAP: begin
                  if (s.gap_cnt[c] == estu_pkg::GAP_CYC - 2'h2) begin
                     next_s.st[c] = estu_pkg::CH_IDLE;
                  end else begin
                     next_s.gap_cnt[c] = s.gap_cnt[c] + 2'h1;
                  end
               end
               default: begin
                  next_s.st[c] = estu_pkg::CH_IDLE;
                  next_s.rstb[c] = 1'b1;
               end
            endcase
         end
      end
      // AXI4-Lite write: address and data taken in either order
      if (awvalid && awready) begin
         next_s.aw_held = 1'b1;
         next_s.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_s.w_held = 1'b1;
         next_s.w_data = wdata;
         next_s.w_strb = wstrb;
      end
      next_s.ovf = s.ovf | ovf_set; // Set wins over a same-cycle clear
      if (s.aw_held && s.w_held) begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = estu_pkg::RESP_OKAY;
         if (s.aw_addr == estu_pkg::ADDR_SYNC_POL) begin
            if (s.w_strb[0]) next_s.sy_pol = s.w_data[estu_pkg::POL_BIT];
         end else if (s.aw_addr == estu_pkg::ADDR_RES_CFG) begin
            if (s.w_strb[0]) next_s.word_len = s.w_data[estu_pkg::CFG_LEN_LSB +: 6];
            if (s.w_strb[1]) next_s.half_div = s.w_data[estu_pkg::CFG_DIV_LSB +: 8];
         end else if (s.aw_addr == estu_pkg::ADDR_STATUS) begin
            if (s.w_strb[0]) next_s.ovf = (s.ovf & ~s.w_data[estu_pkg::ST_OVF_LSB +: 4]) | ovf_set;
         end else if ((s.aw_addr[4:0] == 5'h00) && (s.aw_addr[7] == 1'b0)) begin
            if (s.w_strb[0]) next_s.ev_pol[s.aw_addr[6:5]] = s.w_data[estu_pkg::POL_BIT];
         end else begin
            next_s.bresp = estu_pkg::RESP_DECERR;
         end
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      // AXI4-Lite read: answer one cycle after the address is taken
      if (arvalid && arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = estu_pkg::RESP_OKAY;
         next_s.rdata = 32'h0000_0000;
         if (araddr == estu_pkg::ADDR_SYNC_POL) begin
            next_s.rdata[estu_pkg::POL_BIT] = s.sy_pol;
         end else if (araddr == estu_pkg::ADDR_RES_CFG) begin
            next_s.rdata[estu_pkg::CFG_LEN_LSB +: 6] = s.word_len;
            next_s.rdata[estu_pkg::CFG_DIV_LSB +: 8] = s.half_div;
         end else if (araddr == estu_pkg::ADDR_STATUS) begin
            next_s.rdata[estu_pkg::ST_NEMPTY_LSB +: 4] = ~ch_empty;
            next_s.rdata[estu_pkg::ST_OVF_LSB +: 4] = s.ovf;
            for (int c = 0; c < 4; c++) begin
               next_s.rdata[estu_pkg::ST_BUSY_LSB + c] = (s.st[c] != estu_pkg::CH_IDLE);
            end
         end else if ((araddr[4:0] == 5'h00) && (araddr[7] == 1'b0)) begin
            next_s.rdata[estu_pkg::POL_BIT] = s.ev_pol[araddr[6:5]];
         end else begin
            next_s.rresp = estu_pkg::RESP_DECERR;
         end
      end else if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; reset empties FIFOs and idles the shifters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.ev_pol <= {4{estu_pkg::RST_POL}};
         s.sy_pol <= estu_pkg::RST_POL;
         s.word_len <= estu_pkg::RST_WORD_LEN;
         s.half_div <= estu_pkg::RST_HALF_DIV;
         for (int c = 0; c < 4; c++) begin
            s.st[c] <= estu_pkg::CH_IDLE;
         end
         s.rstb <= 4'hf;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign awready = ~s.aw_held & ~s.bvalid;
   assign wready = ~s.w_held & ~s.bvalid;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = ~s.rvalid;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign result_clk = s.rclk;
   assign result_data = s.rdat;
   assign result_strobe = s.rstb;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   reset_empty_a: assert property ($rose(aresetn) |-> ch_empty == 4'hf && result_strobe == 4'hf)
      else $error("FIFO or strobe not idle after reset");
   counter_step_a: assert property ($past(aresetn) |-> s.count == $past(s.count) + 34'h0_0000_0006)
      else $error("Stamp counter did not advance by six");
   stamp_push_a: assert property (acc_ev[0] && !ch_full[0] |=>
                                  s.fifo[0][$past(s.wr_ptr[0][PTR_W-1:0])] == $past(s.count))
      else $error("Event stamp not stored");
   sync_stamp_a: assert property (acc_sy |=> s.sync_stamp == $past(s.count))
      else $error("Sync stamp not captured");
   diff_load_a: assert property (load_ch[1] |=>
                                 s.shreg[1] == $past(stamp_diff(s.fifo[1][s.rd_ptr[1][PTR_W-1:0]], s.sync_stamp)))
      else $error("Loaded result is not event minus sync");
   sync_polarity_a: assert property (acc_sy |-> s.sy_sync == ~s.sy_pol)
      else $error("Sync edge taken with wrong polarity");
   event_polarity_a: assert property (acc_ev[2] |-> s.ev_sync[2] != s.ev_pol[2] && s.ev_prev[2] == s.ev_pol[2])
      else $error("Event edge taken with wrong polarity");
   frame_strobe_a: assert property (load_ch[0] |=> !result_strobe[0] && result_data[0] == estu_pkg::TAG_VALUE)
      else $error("Frame did not open with low strobe and tag");
   frame_end_a: assert property (launch && s.st[0] == estu_pkg::CH_SEND && s.bit_cnt[0] == eff_len |=>
                                 result_strobe[0] && s.st[0] == estu_pkg::CH_GAP)
      else $error("Strobe did not rise after last bit");
   lockout_a: assert property (acc_ev[3] |=> !acc_ev[3])
      else $error("Event edge accepted inside the lockout");
   launch_edge_a: assert property (launch |=> !result_clk)
      else $error("Data launched away from the falling result clock");

   frame_c: cover property (load_ch[0] ##[1:1000] s.st[0] == estu_pkg::CH_GAP);
   negative_c: cover property (load_ch[0] ##1 s.shreg[0][estu_pkg::RESULT_W-1]);
   overflow_c: cover property (ovf_set != 4'h0);
   all_busy_c: cover property (result_strobe == 4'h0);
endmodule // estu_core

/* File: include/estu_pkg.sv */
// Shared constants and types for the event-to-sync time-interval unit
package estu_pkg;
   // Bus geometry
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   // Register byte addresses
   localparam logic [7:0]  ADDR_EV_POL0    = 8'h00;
   localparam logic [7:0]  ADDR_EV_STRIDE  = 8'h20;
   localparam logic [7:0]  ADDR_SYNC_POL   = 8'h80;
   localparam logic [7:0]  ADDR_RES_CFG    = 8'h84;
   localparam logic [7:0]  ADDR_STATUS     = 8'h88;
   // Field positions
   localparam int          POL_BIT         = 0;
   localparam int          CFG_LEN_LSB     = 0;
   localparam int          CFG_DIV_LSB     = 8;
   localparam int          ST_NEMPTY_LSB   = 0;
   localparam int          ST_OVF_LSB      = 4;
   localparam int          ST_BUSY_LSB     = 8;
   // Reset values
   localparam logic [5:0]  RST_WORD_LEN    = 6'h28;
   localparam logic [7:0]  RST_HALF_DIV    = 8'h08;
   localparam logic        RST_POL         = 1'h0;
   // Result word
   localparam int          STAMP_W         = 34;
   localparam int          RESULT_W        = 40;
   localparam logic [5:0]  MAX_WORD_LEN    = 6'h28;
   localparam logic        TAG_VALUE       = 1'h0;
   localparam logic [1:0]  GAP_CYC         = 2'h2;
   // Timing
   localparam int          CLK_MHZ         = 200;
   localparam int          CLK_PERIOD_NS   = 5;
   localparam int          COUNTER_MHZ     = 1200;
   localparam int          TICKS_PER_CLK   = COUNTER_MHZ / CLK_MHZ;
   localparam int          LOCKOUT_NS      = 5;
   localparam int          LOCKOUT_CALC    = (LOCKOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          LOCKOUT_CYC     = (LOCKOUT_CALC < 1) ? 1 : LOCKOUT_CALC;
   // Bus responses
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_DECERR     = 2'h3;
   // Per-channel result shifter states
   typedef enum logic [2:0] {
      CH_IDLE = 3'b001,
      CH_SEND = 3'b010,
      CH_GAP  = 3'b100
   } estu_ch_state_type;
endpackage
